// ---- rtl/fpu_exc_pkg.sv ----
// constants, field layout and shared functions of the fpu exception and status block
// Behaviour
// - sign operation compliance bit sits at bit 19, fixed by hardware
// - compliance bit 0: magnitude and sign flip treat NaN arithmetically and trap
// - compliance bit 1: magnitude and sign flip accept NaN with no trap
// - NaN encoding bit at bit 18, hardware preset; 0 legacy, 1 newer encoding
// - newer encoding: quiet NaN leading fraction bit 1, signaling NaN 0
// - legacy encoding: quiet NaN leading fraction bit 0, signaling NaN 1
// - every arithmetic instruction rewrites cause bits 17:12 with its own conditions, unless a register write lands in the same cycle
// - enable bit in 11:7 with matching cause bit set raises the exception
// - a register write leaving enable and cause both set also raises it
// - unimplemented operation cause has no enable and always raises the exception
// - untrapped condition sets its flag in 6:2, other flags unchanged
// - an operation that raises the exception leaves all flags unchanged
// - hardware never clears flags; only software writes clear them
// - rounding field 1:0 selects rounding unless operation fixes its own mode
// - cause order high to low: unimpl, invalid, div0, overflow, underflow, inexact
// - rounding codes: 0 nearest even, 1 zero, 2 plus inf, 3 minus inf
package fpu_exc_pkg;

    // field positions in the full control and status view
    localparam int RND_LSB = 0;
    localparam int FLAG_LSB = 2;
    localparam int EN_LSB = 7;
    localparam int CAUSE_LSB = 12;
    localparam int NAN_ENC_POS = 18;
    localparam int SIGN_COMPL_POS = 19;
    localparam int CAUSE_W = 6;
    localparam int IEEE_W = 5;
    localparam int RND_W = 2;

    // cause bit indices, low to high; enables and flags share the low five
    localparam int EXC_INEXACT = 0;
    localparam int EXC_UNDERFLOW = 1;
    localparam int EXC_OVERFLOW = 2;
    localparam int EXC_DIV_ZERO = 3;
    localparam int EXC_INVALID = 4;
    localparam int EXC_UNIMPL = 5;
    localparam logic [CAUSE_W-1:0] CAUSE_UNIMPL_ONLY = 6'h20;

    // rounding field codes
    localparam logic [RND_W-1:0] RND_NEAREST_EVEN = 2'h0;
    localparam logic [RND_W-1:0] RND_TOWARD_ZERO = 2'h1;
    localparam logic [RND_W-1:0] RND_PLUS_INF = 2'h2;
    localparam logic [RND_W-1:0] RND_MINUS_INF = 2'h3;

    // register views selectable by the move instructions
    localparam logic [1:0] VIEW_FULL = 2'h0;
    localparam logic [1:0] VIEW_EXCEPT = 2'h1;
    localparam logic [1:0] VIEW_ENABLE = 2'h2;

    // operand formats for NaN detection
    localparam int SGL_EXP_MSB = 30;
    localparam int SGL_EXP_LSB = 23;
    localparam int SGL_LEAD_POS = 22;
    localparam int DBL_EXP_MSB = 62;
    localparam int DBL_EXP_LSB = 52;
    localparam int DBL_LEAD_POS = 51;

    // unimplemented operation is always enabled
    function automatic logic trap_hit(input logic [CAUSE_W-1:0] cause, input logic [IEEE_W-1:0] en);
        trap_hit = cause[EXC_UNIMPL] | (|(cause[IEEE_W-1:0] & en));
    endfunction

    // readback of one view; unknown views read zero
    function automatic logic [31:0] read_view(input logic [1:0] view, input logic [CAUSE_W-1:0] cause,
                                              input logic [IEEE_W-1:0] en, input logic [IEEE_W-1:0] flags,
                                              input logic [RND_W-1:0] rnd, input logic compl,
                                              input logic nan_enc);
        logic [31:0] r;
        r = 32'h0;
        if (view == VIEW_FULL || view == VIEW_EXCEPT) begin
            r[CAUSE_LSB +: CAUSE_W] = cause;
            r[FLAG_LSB +: IEEE_W] = flags;
        end
        if (view == VIEW_FULL || view == VIEW_ENABLE) begin
            r[EN_LSB +: IEEE_W] = en;
            r[RND_LSB +: RND_W] = rnd;
        end
        if (view == VIEW_FULL) begin
            r[SIGN_COMPL_POS] = compl;
            r[NAN_ENC_POS] = nan_enc;
        end
        read_view = r;
    endfunction

endpackage

// ---- rtl/fpu_nan_classifier.sv ----
// NaN detection and quiet or signaling classification of one operand
`timescale 1ns/10ps
`default_nettype none
module fpu_nan_classifier
    import fpu_exc_pkg::*;
#(
    parameter bit NAN_ENCODING_2008 = 1'b1
) (
    // operand, single in the low word
    input wire logic [63:0] i_operand,
    input wire logic i_double,
    // classification
    output logic o_nan,
    output logic o_quiet,
    output logic o_signaling
);
    logic exp_ones;
    logic frac_nz;
    logic lead;

    // pick exponent and fraction of the selected format
    always_comb begin
        if (i_double) begin
            exp_ones = &i_operand[DBL_EXP_MSB:DBL_EXP_LSB];
            frac_nz = |i_operand[DBL_EXP_LSB-1:0];
            lead = i_operand[DBL_LEAD_POS];
        end else begin
            exp_ones = &i_operand[SGL_EXP_MSB:SGL_EXP_LSB];
            frac_nz = |i_operand[SGL_EXP_LSB-1:0];
            lead = i_operand[SGL_LEAD_POS];
        end
    end

    // polarity of the leading fraction bit flips with the encoding
    assign o_nan = exp_ones & frac_nz;
    assign o_quiet = o_nan & (lead == NAN_ENCODING_2008);
    assign o_signaling = o_nan & (lead != NAN_ENCODING_2008);
endmodule
`default_nettype wire

// ---- rtl/fpu_exc_update.sv ----
// trap decision and sticky flag update for one completed arithmetic operation
`timescale 1ns/10ps
`default_nettype none
module fpu_exc_update
    import fpu_exc_pkg::*;
(
    // conditions raised and current state
    input wire logic [CAUSE_W-1:0] i_raised,
    input wire logic [IEEE_W-1:0] i_enables,
    input wire logic [IEEE_W-1:0] i_flags,
    // results
    output logic o_trap,
    output logic [IEEE_W-1:0] o_next_flags
);
    // a trapping operation must not touch the flags at all
    always_comb begin
        o_trap = trap_hit(i_raised, i_enables);
        if (o_trap) begin
            o_next_flags = i_flags;
        end else begin
            o_next_flags = i_flags | i_raised[IEEE_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fpu_exception_status_control.sv ----
// floating point control and status register with cause, enables, flags and rounding logic
`timescale 1ns/10ps
`default_nettype none
module fpu_exception_status_control
    import fpu_exc_pkg::*;
#(
    parameter bit SIGN_OP_COMPLIANCE = 1'b1,
    parameter bit NAN_ENCODING_2008 = 1'b1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // coprocessor move access
    input wire logic i_ctl_wr,
    input wire logic i_ctl_rd,
    input wire logic [1:0] i_ctl_view,
    input wire logic [31:0] i_ctl_wdata,
    output logic [31:0] o_ctl_rdata,
    // arithmetic completion from the datapath
    input wire logic i_op_done,
    input wire logic [CAUSE_W-1:0] i_op_cause,
    input wire logic i_op_sign_op,
    input wire logic [63:0] i_op_operand,
    input wire logic i_op_double,
    // rounding request
    input wire logic i_op_rnd_fixed,
    input wire logic [RND_W-1:0] i_op_rnd_value,
    output logic [RND_W-1:0] o_round_mode,
    // NaN classification service
    input wire logic [63:0] i_class_operand,
    input wire logic i_class_double,
    output logic o_class_quiet,
    output logic o_class_signaling,
    // exception request to the core
    output logic o_fp_exception
);
    // architectural fields
    logic [CAUSE_W-1:0] cause;
    logic [IEEE_W-1:0] enables;
    logic [IEEE_W-1:0] flags;
    logic [RND_W-1:0] rounding_field;
    logic [CAUSE_W-1:0] next_cause;
    logic [IEEE_W-1:0] next_enables;
    logic [IEEE_W-1:0] next_flags;
    logic [RND_W-1:0] next_rounding_field;
    logic next_fp_exception;
    logic [31:0] next_ctl_rdata;
    logic [RND_W-1:0] next_round_mode;
    logic next_class_quiet;
    logic next_class_signaling;

    // operand checks and update results
    logic op_nan;
    logic cls_quiet;
    logic cls_signaling;
    logic op_is_arith;
    logic [CAUSE_W-1:0] op_raised;
    logic op_trap;
    logic [IEEE_W-1:0] op_flags;
    logic wr_view_ok;

    // operand of a magnitude or sign flip op
    fpu_nan_classifier #(
        .NAN_ENCODING_2008(NAN_ENCODING_2008)
    ) u_op_nan (
        .i_operand(i_op_operand),
        .i_double(i_op_double),
        .o_nan(op_nan),
        .o_quiet(),
        .o_signaling()
    );

    // classification offered to the datapath
    fpu_nan_classifier #(
        .NAN_ENCODING_2008(NAN_ENCODING_2008)
    ) u_class_nan (
        .i_operand(i_class_operand),
        .i_double(i_class_double),
        .o_nan(),
        .o_quiet(cls_quiet),
        .o_signaling(cls_signaling)
    );

    // legacy sign ops are arithmetic and refuse NaN through the unimplemented cause
    always_comb begin
        op_is_arith = !i_op_sign_op || !SIGN_OP_COMPLIANCE;
        if (i_op_sign_op) begin
            op_raised = (op_nan && !SIGN_OP_COMPLIANCE) ? CAUSE_UNIMPL_ONLY : '0;
        end else begin
            op_raised = i_op_cause;
        end
    end

    fpu_exc_update u_update (
        .i_raised(op_raised),
        .i_enables(enables),
        .i_flags(flags),
        .o_trap(op_trap),
        .o_next_flags(op_flags)
    );

    assign wr_view_ok = (i_ctl_view == VIEW_FULL) || (i_ctl_view == VIEW_EXCEPT) || (i_ctl_view == VIEW_ENABLE);

    // next state; a move instruction wins over a completion in the same cycle
    // a completion under a write loses its cause, only its untrapped flags survive
    always_comb begin
        next_cause = cause;
        next_enables = enables;
        next_flags = flags;
        next_rounding_field = rounding_field;
        next_fp_exception = 1'b0;
        if (i_ctl_wr && wr_view_ok) begin
            if (i_ctl_view != VIEW_ENABLE) begin
                next_cause = i_ctl_wdata[CAUSE_LSB +: CAUSE_W];
                next_flags = i_ctl_wdata[FLAG_LSB +: IEEE_W];
            end
            if (i_ctl_view != VIEW_EXCEPT) begin
                next_enables = i_ctl_wdata[EN_LSB +: IEEE_W];
                next_rounding_field = i_ctl_wdata[RND_LSB +: RND_W];
            end
            next_fp_exception = trap_hit(next_cause, next_enables);
            // hardware set beats a software clear in the same cycle
            if (i_op_done && op_is_arith && !op_trap) begin
                next_flags = next_flags | op_raised[IEEE_W-1:0];
            end
        end else if (i_op_done && op_is_arith) begin
            next_cause = op_raised;
            next_flags = op_flags;
            next_fp_exception = op_trap;
        end
    end

    // readback, rounding selection and classification outputs
    always_comb begin
        next_ctl_rdata = o_ctl_rdata;
        if (i_ctl_rd) begin
            next_ctl_rdata = read_view(i_ctl_view, cause, enables, flags, rounding_field,
                                       SIGN_OP_COMPLIANCE, NAN_ENCODING_2008);
        end
        next_round_mode = i_op_rnd_fixed ? i_op_rnd_value : rounding_field;
        next_class_quiet = cls_quiet;
        next_class_signaling = cls_signaling;
    end

    // fields reset to zero for determinism, software must not rely on it
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cause <= '0;
            enables <= '0;
            flags <= '0;
            rounding_field <= RND_NEAREST_EVEN;
            o_fp_exception <= 1'b0;
            o_ctl_rdata <= '0;
            o_round_mode <= RND_NEAREST_EVEN;
            o_class_quiet <= 1'b0;
            o_class_signaling <= 1'b0;
        end else begin
            cause <= next_cause;
            enables <= next_enables;
            flags <= next_flags;
            rounding_field <= next_rounding_field;
            o_fp_exception <= next_fp_exception;
            o_ctl_rdata <= next_ctl_rdata;
            o_round_mode <= next_round_mode;
            o_class_quiet <= next_class_quiet;
            o_class_signaling <= next_class_signaling;
        end
    end

    // checks on the registered behaviour
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    AST_SIGN_BIT_FIXED: assert property (
        i_ctl_rd && i_ctl_view == VIEW_FULL |=> o_ctl_rdata[SIGN_COMPL_POS] == SIGN_OP_COMPLIANCE)
        else $error("sign op compliance bit reads wrong");

    AST_NAN_BIT_FIXED: assert property (
        i_ctl_rd && i_ctl_view == VIEW_FULL |=> o_ctl_rdata[NAN_ENC_POS] == NAN_ENCODING_2008)
        else $error("nan encoding bit reads wrong");

    AST_LEGACY_SIGN_TRAP: assert property (
        !i_ctl_wr && i_op_done && i_op_sign_op && op_nan && !SIGN_OP_COMPLIANCE
        |=> o_fp_exception && cause[EXC_UNIMPL])
        else $error("legacy sign op on NaN did not trap");

    AST_COMPLIANT_SIGN_QUIET: assert property (
        !i_ctl_wr && i_op_done && i_op_sign_op && SIGN_OP_COMPLIANCE
        |=> !o_fp_exception && $stable(cause) && $stable(flags))
        else $error("compliant sign op disturbed the state");

    AST_NAN_POLARITY: assert property (
        ##1 (o_class_quiet || o_class_signaling)
        |-> o_class_quiet == ($past(i_class_double) ? ($past(i_class_operand[DBL_LEAD_POS]) == NAN_ENCODING_2008)
                              : ($past(i_class_operand[SGL_LEAD_POS]) == NAN_ENCODING_2008)))
        else $error("quiet and signaling polarity wrong");

    AST_CLASS_EXCLUSIVE: assert property (
        !(o_class_quiet && o_class_signaling))
        else $error("operand classed both quiet and signaling");

    AST_CAUSE_REWRITE: assert property (
        !i_ctl_wr && i_op_done && !i_op_sign_op |=> cause == $past(i_op_cause))
        else $error("cause not rewritten by arithmetic op");

    AST_ARITH_TRAP: assert property (
        !i_ctl_wr && i_op_done && !i_op_sign_op
        |=> o_fp_exception == ($past(i_op_cause[EXC_UNIMPL]) || (|($past(i_op_cause[IEEE_W-1:0]) & $past(enables)))))
        else $error("arithmetic trap decision wrong");

    AST_WRITE_TRAP: assert property (
        i_ctl_wr && i_ctl_view == VIEW_FULL
        && (|(i_ctl_wdata[CAUSE_LSB +: IEEE_W] & i_ctl_wdata[EN_LSB +: IEEE_W]))
        |=> o_fp_exception)
        else $error("write with enabled cause did not trap");

    AST_UNIMPL_ALWAYS: assert property (
        ##1 $changed(cause) && cause[EXC_UNIMPL] |-> o_fp_exception)
        else $error("unimplemented cause set without exception");

    AST_FLAGS_NEVER_DROP: assert property (
        !i_ctl_wr |=> (flags & $past(flags)) == $past(flags))
        else $error("hardware cleared a flag bit");

    AST_FLAGS_SET_UNTRAPPED: assert property (
        !i_ctl_wr && i_op_done && !i_op_sign_op && !op_trap
        |=> flags == ($past(flags) | $past(i_op_cause[IEEE_W-1:0])))
        else $error("untrapped condition did not set its flag");

    AST_FLAGS_HELD_ON_TRAP: assert property (
        !i_ctl_wr && i_op_done && op_trap |=> $stable(flags) ##1 1'b1)
        else $error("trapping op changed the flags");

    AST_ROUND_SELECT: assert property (
        !i_op_rnd_fixed && !$past(i_ctl_wr) |=> o_round_mode == $past(rounding_field))
        else $error("rounding field not applied");

    AST_ROUND_FIXED: assert property (
        i_op_rnd_fixed |=> o_round_mode == $past(i_op_rnd_value))
        else $error("mandated rounding mode not applied");

    // register bus scope and refusal
    AST_FULL_WRITE_LANDS: assert property (
        i_ctl_wr && i_ctl_view == VIEW_FULL
        |=> cause == $past(i_ctl_wdata[CAUSE_LSB +: CAUSE_W]) && enables == $past(i_ctl_wdata[EN_LSB +: IEEE_W])
            && rounding_field == $past(i_ctl_wdata[RND_LSB +: RND_W]))
        else $error("full view write did not land");

    AST_EXCEPT_VIEW_SCOPE: assert property (
        i_ctl_wr && i_ctl_view == VIEW_EXCEPT |=> $stable(enables) && $stable(rounding_field))
        else $error("exceptions view write touched enables or rounding");

    AST_ENABLE_VIEW_SCOPE: assert property (
        i_ctl_wr && i_ctl_view == VIEW_ENABLE |=> $stable(cause))
        else $error("enables view write touched the cause bits");

    // the unmapped view must be a no-op, else a stray move corrupts state
    AST_UNMAPPED_WRITE_IGNORED: assert property (
        i_ctl_wr && !wr_view_ok && !i_op_done
        |=> $stable(cause) && $stable(enables) && $stable(flags) && $stable(rounding_field) && !o_fp_exception)
        else $error("write to the unmapped view changed state");

    AST_UNMAPPED_READ_ZERO: assert property (
        i_ctl_rd && !wr_view_ok |=> o_ctl_rdata == '0)
        else $error("read of the unmapped view returned data");

    AST_EXCEPT_VIEW_READ: assert property (
        i_ctl_rd && i_ctl_view == VIEW_EXCEPT
        |=> o_ctl_rdata[EN_LSB +: IEEE_W] == '0 && o_ctl_rdata[RND_LSB +: RND_W] == '0)
        else $error("exceptions view read shows enables or rounding");

    AST_ENABLE_VIEW_READ: assert property (
        i_ctl_rd && i_ctl_view == VIEW_ENABLE
        |=> o_ctl_rdata[CAUSE_LSB +: CAUSE_W] == '0 && o_ctl_rdata[FLAG_LSB +: IEEE_W] == '0)
        else $error("enables view read shows cause or flags");

    // read data is held so a late consumer still sees the last read
    AST_RDATA_HOLDS: assert property (
        !i_ctl_rd |=> $stable(o_ctl_rdata))
        else $error("read data changed without a read");

    // exception source and collisions
    AST_EXC_ONLY_ON_EVENT: assert property (
        ##1 o_fp_exception |-> $past(i_ctl_wr) || $past(i_op_done))
        else $error("exception raised with no write or completion");

    AST_LEGACY_SIGN_PLAIN: assert property (
        !i_ctl_wr && i_op_done && i_op_sign_op && !op_nan && !SIGN_OP_COMPLIANCE
        |=> !o_fp_exception && cause == '0 && $stable(flags))
        else $error("legacy sign op on a number misbehaved");

    AST_FLAG_SET_BEATS_CLEAR: assert property (
        i_ctl_wr && i_op_done && op_is_arith && !op_trap
        |=> (flags & $past(op_raised[IEEE_W-1:0])) == $past(op_raised[IEEE_W-1:0]))
        else $error("flag raised during a software write was lost");

    COV_ARITH_TRAP: cover property (i_op_done && !i_op_sign_op ##1 o_fp_exception);
    COV_FLAG_ACCUM: cover property (i_op_done && !op_trap ##1 i_op_done && !op_trap ##1 (|flags));
    COV_WRITE_TRAP: cover property (i_ctl_wr ##1 o_fp_exception);
    COV_SIGN_NAN: cover property (i_op_done && i_op_sign_op && op_nan);
    COV_SET_BEATS_CLEAR: cover property (i_ctl_wr && i_op_done && !op_trap ##1 (|flags));
endmodule
`default_nettype wire

// ---- tb/fpu_datapath_model.sv ----
// behavioural model of the arithmetic datapath that reports completed instructions
`timescale 1ns/10ps
`default_nettype none
module fpu_datapath_model
    import fpu_exc_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // completion report
    output logic o_op_done,
    output logic [CAUSE_W-1:0] o_op_cause,
    output logic o_op_sign_op,
    output logic [63:0] o_op_operand,
    output logic o_op_double
);
    // idle state at time zero
    initial begin
        o_op_done = 1'b0;
        o_op_cause = 6'h00;
        o_op_sign_op = 1'b0;
        o_op_operand = 64'h0;
        o_op_double = 1'b0;
    end

    // one completion pulse per instruction, its own conditions only
    task automatic issue(input logic [CAUSE_W-1:0] cause, input logic sign_op, input logic [63:0] operand,
                         input logic dbl);
        @(posedge i_sys_clk);
        o_op_done <= 1'b1;
        o_op_cause <= cause;
        o_op_sign_op <= sign_op;
        o_op_operand <= operand;
        o_op_double <= dbl;
        @(posedge i_sys_clk);
        // released lines other than the format bit show garbage so stale values cannot pass
        o_op_done <= 1'b0;
        o_op_cause <= ~cause;
        o_op_sign_op <= ~sign_op;
        o_op_operand <= ~operand;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the exception and status block, modern and legacy presets side by side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fpu_exc_pkg::*;

    logic i_sys_clk, i_rst, ctl_wr, ctl_rd, op_done, op_sign, op_double, rnd_fixed, cls_double;
    logic [1:0] ctl_view, rnd_value, round_a, round_b;
    logic [31:0] wdata, rdata_a, rdata_b;
    logic [5:0] op_cause, c;
    logic [63:0] op_operand, cls_operand;
    logic q_a, s_a, q_b, s_b, exc_a, exc_b;
    logic [4:0] f;
    int fail_count, check_count, j;

    // clock and start values
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        i_rst = 1'b1; ctl_wr = 1'b0; ctl_rd = 1'b0; ctl_view = 2'h0; wdata = 32'h0;
        rnd_fixed = 1'b0; rnd_value = 2'h0; cls_operand = 64'h0; cls_double = 1'b0;
        fail_count = 0; check_count = 0;
    end

    fpu_datapath_model pm (.i_sys_clk(i_sys_clk), .o_op_done(op_done), .o_op_cause(op_cause),
        .o_op_sign_op(op_sign), .o_op_operand(op_operand), .o_op_double(op_double));

    // both instances see the same stimulus; only presets differ
    fpu_exception_status_control #(.SIGN_OP_COMPLIANCE(1'b1), .NAN_ENCODING_2008(1'b1)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ctl_wr(ctl_wr), .i_ctl_rd(ctl_rd), .i_ctl_view(ctl_view),
        .i_ctl_wdata(wdata), .o_ctl_rdata(rdata_a), .i_op_done(op_done), .i_op_cause(op_cause),
        .i_op_sign_op(op_sign), .i_op_operand(op_operand), .i_op_double(op_double),
        .i_op_rnd_fixed(rnd_fixed), .i_op_rnd_value(rnd_value), .o_round_mode(round_a),
        .i_class_operand(cls_operand), .i_class_double(cls_double), .o_class_quiet(q_a),
        .o_class_signaling(s_a), .o_fp_exception(exc_a));
    fpu_exception_status_control #(.SIGN_OP_COMPLIANCE(1'b0), .NAN_ENCODING_2008(1'b0)) dut_legacy (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ctl_wr(ctl_wr), .i_ctl_rd(ctl_rd), .i_ctl_view(ctl_view),
        .i_ctl_wdata(wdata), .o_ctl_rdata(rdata_b), .i_op_done(op_done), .i_op_cause(op_cause),
        .i_op_sign_op(op_sign), .i_op_operand(op_operand), .i_op_double(op_double),
        .i_op_rnd_fixed(rnd_fixed), .i_op_rnd_value(rnd_value), .o_round_mode(round_b),
        .i_class_operand(cls_operand), .i_class_double(cls_double), .o_class_quiet(q_b),
        .o_class_signaling(s_b), .o_fp_exception(exc_b));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // register write, then the exception pulse of both instances
    task automatic wr_reg(input logic [1:0] v, input logic [31:0] d, input logic exp_exc);
        @(posedge i_sys_clk);
        ctl_wr <= 1'b1; ctl_view <= v; wdata <= d;
        @(posedge i_sys_clk);
        ctl_wr <= 1'b0; wdata <= ~d;
        #1 chk_bit(exc_a, exp_exc);
        chk_bit(exc_b, exp_exc);
    endtask

    task automatic rd_pair(input logic [1:0] v, input logic [31:0] ea, input logic [31:0] eb);
        @(posedge i_sys_clk);
        ctl_rd <= 1'b1; ctl_view <= v;
        @(posedge i_sys_clk);
        ctl_rd <= 1'b0;
        #1 chk_word(rdata_a, ea);
        chk_word(rdata_b, eb);
    endtask

    // legacy instance has both presets at zero
    task automatic rd_reg(input logic [1:0] v, input logic [31:0] e);
        rd_pair(v, e, e & 32'hfff3ffff);
    endtask

    task automatic op(input logic [5:0] cause, input logic exp_exc);
        pm.issue(cause, 1'b0, 64'h3ff0000000000000, 1'b1);
        #1 chk_bit(exc_a, exp_exc);
        chk_bit(exc_b, exp_exc);
    endtask

    task automatic sign_op(input logic [63:0] d, input logic ea, input logic eb);
        pm.issue(6'h00, 1'b1, d, 1'b0);
        #1 chk_bit(exc_a, ea);
        chk_bit(exc_b, eb);
    endtask

    task automatic rnd_chk(input logic fx, input logic [1:0] val, input logic [1:0] e);
        @(posedge i_sys_clk);
        rnd_fixed <= fx; rnd_value <= val;
        @(posedge i_sys_clk);
        #1 chk_word({30'h0, round_a}, {30'h0, e});
        chk_word({30'h0, round_b}, {30'h0, e});
    endtask

    task automatic cls_chk(input logic [63:0] d, input logic dbl, input logic [3:0] e);
        @(posedge i_sys_clk);
        cls_operand <= d; cls_double <= dbl;
        @(posedge i_sys_clk);
        #1 chk_word({28'h0, q_a, s_a, q_b, s_b}, {28'h0, e});
    endtask

    // hang guard, generous against a run of about 150 cycles
    initial begin
        #40000;
        fail_count++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd_reg(2'h0, 32'h000c0000);
        wr_reg(2'h0, 32'hfff00fd6, 1'b0);
        rd_reg(2'h0, 32'h000c0fd6);
        rd_reg(2'h1, 32'h00000054);
        rd_reg(2'h2, 32'h00000f82);
        rd_reg(2'h3, 32'h00000000);
        wr_reg(2'h3, 32'h0003ffff, 1'b0);
        rd_reg(2'h0, 32'h000c0fd6);
        wr_reg(2'h0, 32'h00010800, 1'b1);
        wr_reg(2'h0, 32'h00020000, 1'b1);
        wr_reg(2'h1, 32'h00001000, 1'b0);
        rd_reg(2'h0, 32'h000c1000);
        wr_reg(2'h2, 32'h00000000, 1'b0);
        op(6'h01, 1'b0);
        rd_reg(2'h1, 32'h00001004);
        op(6'h02, 1'b0);
        rd_reg(2'h1, 32'h0000200c);
        op(6'h00, 1'b0);
        rd_reg(2'h1, 32'h0000000c);
        wr_reg(2'h2, 32'h00000200, 1'b0);
        op(6'h05, 1'b1);
        rd_reg(2'h1, 32'h0000500c);
        op(6'h20, 1'b1);
        rd_reg(2'h1, 32'h0002000c);
        wr_reg(2'h1, 32'h00000000, 1'b0);
        rd_reg(2'h1, 32'h00000000);
        // walk each ieee condition: trapped with its enable, then a neighbour untrapped
        // from the second pass the standing neighbour cause meets its new enable, so the write traps
        f = 5'h00;
        for (int i = 0; i < 5; i++) begin
            j = (i + 1) % 5;
            f[j] = 1'b1;
            c = 6'h00;
            c[i] = 1'b1;
            wr_reg(2'h2, 32'h00000080 << i, i != 0);
            op(c, 1'b1);
            c = 6'h00;
            c[j] = 1'b1;
            op(c, 1'b0);
            rd_reg(2'h1, (32'h00001000 << j) | {25'h0, f, 2'h0});
        end
        for (int m = 0; m < 4; m++) begin
            wr_reg(2'h2, 32'(m), 1'b0);
            rnd_chk(1'b0, ~2'(m), 2'(m));
            rnd_chk(1'b1, ~2'(m), ~2'(m));
        end
        rnd_chk(1'b0, 2'h0, 2'h3);
        cls_chk(64'h000000007fc00000, 1'b0, 4'h9);
        cls_chk(64'h000000007fa00000, 1'b0, 4'h6);
        cls_chk(64'h7ff8000000000000, 1'b1, 4'h9);
        cls_chk(64'h7ff4000000000000, 1'b1, 4'h6);
        cls_chk(64'h000000003f800000, 1'b0, 4'h0);
        sign_op(64'h000000007fc00000, 1'b0, 1'b1);
        rd_pair(2'h1, 32'h0000107c, 32'h0002007c);
        sign_op(64'h000000003f800000, 1'b0, 1'b0);
        rd_pair(2'h1, 32'h0000107c, 32'h0000007c);
        // a software clear colliding with an untrapped condition keeps the new flag
        fork
            wr_reg(2'h1, 32'h00000000, 1'b0);
            pm.issue(6'h02, 1'b0, 64'h0, 1'b1);
        join
        rd_reg(2'h1, 32'h00000008);
        stop_test();
    end
endmodule
`default_nettype wire
